/* verilog/sas_ctrl.sv */
// Purpose: Session security states, attempt counters and write sequencing.
// Assumes: Command decoder and EEPROM controller share i_clk.
// Notes: Cipher, CRC and user password compare live outside this block; the transport password is compared here.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_ctrl #(
    parameter int NUM_ZONES = 16,
    parameter int NUM_PW_SETS = 8,
    parameter int ADDR_W = 13,
    parameter int CNT_W = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_cmd_valid,
    input wire sas_pkg::sas_cmd_t i_cmd_code,
    input wire logic i_cmd_ok,
    input wire logic i_cmd_cfg,
    input wire logic [$clog2(NUM_ZONES)-1:0] i_cmd_zone,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic [3:0] i_cmd_len,
    input wire logic [$clog2(NUM_PW_SETS)-1:0] i_cmd_pw_set,
    input wire logic i_cmd_pw_write,
    input wire logic [23:0] i_cmd_pw,
    input wire logic i_cmd_has_sum,
    input wire logic i_cmd_sum_ok,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    output logic o_cmd_refuse,
    output sas_pkg::sas_mode_t o_mode,
    output logic o_pw_cipher,
    output logic o_data_cipher,
    output logic o_mac_mode,
    output logic o_pw_read_ok,
    output logic o_pw_write_ok,
    output logic [$clog2(NUM_PW_SETS)-1:0] o_pw_set,
    output logic o_cfg_open,
    input wire logic i_ee_tear_mark,
    input wire logic i_ee_done,
    output logic o_ee_req,
    output sas_pkg::sas_ee_op_t o_ee_op,
    output logic [ADDR_W-1:0] o_ee_addr
);
    localparam int ZONE_W = $clog2(NUM_ZONES);
    localparam int SET_W = $clog2(NUM_PW_SETS);
    localparam int NCNT = 2 * NUM_PW_SETS;
    localparam int CSEL_W = SET_W + 1;

    generate
        if (NUM_ZONES < 2 || NUM_ZONES > 32) begin : g_bad_zones
            $error("sas_ctrl: bad NUM_ZONES");
        end
        if (NUM_PW_SETS < 2 || NUM_PW_SETS > 128) begin : g_bad_sets
            $error("sas_ctrl: bad NUM_PW_SETS");
        end
        if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
            $error("sas_ctrl: bad CNT_W");
        end
        if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
            $error("sas_ctrl: bad ADDR_W");
        end
        // Index widths come from $clog2, so counts must be 2**n
        if ((NUM_ZONES & (NUM_ZONES - 1)) != 0 ||
            (NUM_PW_SETS & (NUM_PW_SETS - 1)) != 0) begin : g_bad_pow2
            $error("sas_ctrl: counts must be powers of two");
        end
    endgenerate

    typedef struct packed {
        sas_pkg::sas_state_t st;
        logic ee_req;
        sas_pkg::sas_ee_op_t ee_op;
        logic [ADDR_W-1:0] dest;
        logic tear_en;
        logic sum_en;
        logic [NUM_ZONES-1:0] enc_zones;
        logic [CSEL_W-1:0] cnt_sel;
        logic [NCNT-1:0][CNT_W-1:0] cnt;
        logic [CNT_W-1:0] auth_cnt;
        logic pw_active;
        logic pw_write;
        logic [SET_W-1:0] pw_set;
        logic cfg_open;
        logic auth_ok;
        logic enc_ok;
        logic done;
        logic refuse;
        logic ack;
        logic [31:0] rdata;
    } sas_regs_t;

    sas_regs_t r_reg;
    sas_regs_t r_next;

    // Zone access blocked by missing encryption or transport password
    function automatic logic access_blocked(
        input logic cfg,
        input logic [ZONE_W-1:0] zone,
        input logic [NUM_ZONES-1:0] enc_zones,
        input logic enc_ok,
        input logic cfg_open
    );
        logic blk;
        blk = 1'b0;
        if (cfg) begin
            blk = !cfg_open;
        end else begin
            blk = enc_zones[zone] && !enc_ok;
        end
        return blk;
    endfunction

    // Saturating, so no attack can wrap a counter
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        logic [CNT_W-1:0] res;
        res = (&v) ? v : v + 1'b1;
        return res;
    endfunction

    always_comb begin
        logic [31:0] mask;
        logic [31:0] rd;
        logic [CSEL_W-1:0] fidx;

        r_next = r_reg;

        mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
        rd = 32'h0000_0000;
        fidx = {i_cmd_pw_set, i_cmd_pw_write};
        r_next.done = 1'b0;
        r_next.refuse = 1'b0;
        r_next.ack = 1'b0;

        // Register bus: one wait state, unmapped reads as zero
        // A write lands on the edge that raises ack
        if (i_wb_cyc && i_wb_stb && !r_reg.ack) begin
            r_next.ack = 1'b1;
            unique case (i_wb_adr[7:2])
                `SAS_OFS_CTRL: begin
                    rd[`SAS_CTRL_TEAR_BIT] = r_reg.tear_en;
                    rd[`SAS_CTRL_SUM_BIT] = r_reg.sum_en;
                    if (i_wb_we && i_wb_sel[0]) begin
                        r_next.tear_en = i_wb_dat[`SAS_CTRL_TEAR_BIT];
                        r_next.sum_en = i_wb_dat[`SAS_CTRL_SUM_BIT];
                    end
                end
                `SAS_OFS_ENC_ZONES: begin
                    rd[NUM_ZONES-1:0] = r_reg.enc_zones;
                    if (i_wb_we) begin
                        r_next.enc_zones = NUM_ZONES'(
                            ({{(32-NUM_ZONES){1'b0}}, r_reg.enc_zones}
                             & ~mask) | (i_wb_dat & mask));
                    end
                end
                `SAS_OFS_STATUS: begin
                    rd[`SAS_ST_MODE_LSB +: 2] = o_mode;
                    rd[`SAS_ST_PW_ACT_BIT] = r_reg.pw_active;
                    rd[`SAS_ST_PW_WR_BIT] = r_reg.pw_write;
                    rd[`SAS_ST_CFG_BIT] = r_reg.cfg_open;
                    rd[`SAS_ST_BUSY_BIT] = !o_cmd_ready;
                    rd[`SAS_ST_PW_SET_LSB +: SET_W] = r_reg.pw_set;
                end
                `SAS_OFS_CNT_SEL: begin
                    rd[CSEL_W-1:0] = r_reg.cnt_sel;
                    if (i_wb_we && i_wb_sel[0]) begin
                        r_next.cnt_sel = i_wb_dat[CSEL_W-1:0];
                    end
                end
                `SAS_OFS_CNT_DATA: begin
                    rd[CNT_W-1:0] = r_reg.cnt[r_reg.cnt_sel];
                    // A failure in the same cycle wins
                    if (i_wb_we) begin
                        r_next.cnt[r_reg.cnt_sel] = '0;
                    end
                end
                `SAS_OFS_AUTH_CNT: begin
                    rd[CNT_W-1:0] = r_reg.auth_cnt;
                    if (i_wb_we) begin
                        r_next.auth_cnt = '0;
                    end
                end
                default: begin
                    rd = 32'h0000_0000;
                end
            endcase
            r_next.rdata = rd;
        end

        // Commands from the decoder, only while idle
        // A bad MAC outranks every other outcome
        if (i_cmd_valid && r_reg.st == sas_pkg::ST_READY) begin
            if (r_reg.auth_ok && i_cmd_has_sum && !i_cmd_sum_ok) begin
                r_next.auth_ok = 1'b0;
                r_next.enc_ok = 1'b0;
                r_next.refuse = 1'b1;
            end else if (!r_reg.auth_ok && r_reg.sum_en && i_cmd_has_sum
                         && !i_cmd_sum_ok) begin
                r_next.refuse = 1'b1;
            end else begin
                unique case (i_cmd_code)
                    sas_pkg::CMD_READ: begin
                        if (access_blocked(i_cmd_cfg, i_cmd_zone,
                            r_reg.enc_zones, r_reg.enc_ok,
                            r_reg.cfg_open)) begin
                            r_next.refuse = 1'b1;
                        end else begin
                            r_next.done = 1'b1;
                        end
                    end
                    sas_pkg::CMD_WRITE: begin
                        if (access_blocked(i_cmd_cfg, i_cmd_zone,
                            r_reg.enc_zones, r_reg.enc_ok,
                            r_reg.cfg_open)) begin
                            r_next.refuse = 1'b1;
                        end else if (r_reg.auth_ok && !i_cmd_has_sum) begin
                            r_next.refuse = 1'b1;
                        end else if (r_reg.tear_en &&
                                     i_cmd_len > `SAS_TEAR_MAX_BYTES) begin
                            r_next.refuse = 1'b1;
                        end else begin
                            r_next.dest = i_cmd_addr;
                            r_next.ee_req = 1'b1;
                            if (r_reg.tear_en) begin
                                r_next.st = sas_pkg::ST_BUF;
                                r_next.ee_op = sas_pkg::EE_WRITE_BUF;
                            end else begin
                                r_next.st = sas_pkg::ST_DIRECT;
                                r_next.ee_op = sas_pkg::EE_WRITE_DIRECT;
                            end
                        end
                    end
                    sas_pkg::CMD_VERIFY_PW: begin
                        r_next.done = 1'b1;
                        if (i_cmd_pw == `SAS_TRANSPORT_PW) begin
                            r_next.cfg_open = 1'b1;
                            r_next.pw_active = 1'b0;
                        end else if (i_cmd_ok) begin
                            r_next.pw_active = 1'b1;
                            r_next.pw_set = i_cmd_pw_set;
                            r_next.pw_write = i_cmd_pw_write;
                            r_next.cfg_open = 1'b0;
                        end else begin
                            r_next.pw_active = 1'b0;
                            r_next.cfg_open = 1'b0;
                            r_next.cnt[fidx] = sat_inc(r_reg.cnt[fidx]);
                        end
                    end
                    sas_pkg::CMD_AUTH: begin
                        r_next.done = 1'b1;
                        r_next.enc_ok = 1'b0;
                        r_next.auth_ok = i_cmd_ok;
                        if (!i_cmd_ok) begin
                            r_next.auth_cnt = sat_inc(r_reg.auth_cnt);
                        end
                    end
                    sas_pkg::CMD_ENC_ACT: begin
                        r_next.done = 1'b1;
                        r_next.enc_ok = i_cmd_ok && r_reg.auth_ok;
                    end
                    sas_pkg::CMD_RELEASE, sas_pkg::CMD_IDLE: begin
                        r_next.done = 1'b1;
                        r_next.pw_active = 1'b0;
                        r_next.cfg_open = 1'b0;
                        r_next.auth_ok = 1'b0;
                        r_next.enc_ok = 1'b0;
                    end
                    sas_pkg::CMD_OTHER: begin
                        r_next.done = 1'b1;
                    end
                endcase
            end
        end

        // Power-up recovery and EEPROM write sequencing
        unique case (r_reg.st)
            sas_pkg::ST_BOOT: begin
                if (i_ee_tear_mark) begin
                    r_next.st = sas_pkg::ST_RESTORE;
                    r_next.ee_req = 1'b1;
                    r_next.ee_op = sas_pkg::EE_COPY;
                end else begin
                    r_next.st = sas_pkg::ST_READY;
                end
            end
            sas_pkg::ST_READY: begin
            end
            default: begin
                if (r_reg.ee_req && i_ee_done) begin
                    r_next.ee_req = 1'b1;
                    unique case (r_reg.st)
                        sas_pkg::ST_RESTORE: begin
                            r_next.st = sas_pkg::ST_RESTORE_CLR;
                            r_next.ee_op = sas_pkg::EE_CLR_MARK;
                        end
                        sas_pkg::ST_BUF: begin
                            r_next.st = sas_pkg::ST_MARK;
                            r_next.ee_op = sas_pkg::EE_SET_MARK;
                        end
                        sas_pkg::ST_MARK: begin
                            r_next.st = sas_pkg::ST_COPY;
                            r_next.ee_op = sas_pkg::EE_COPY;
                        end
                        sas_pkg::ST_COPY: begin
                            r_next.st = sas_pkg::ST_UNMARK;
                            r_next.ee_op = sas_pkg::EE_CLR_MARK;
                        end
                        default: begin
                            r_next.st = sas_pkg::ST_READY;
                            r_next.ee_req = 1'b0;
                            r_next.done = r_reg.st != sas_pkg::ST_RESTORE_CLR;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '0;
            // The tear mark is kept by the EEPROM itself
            r_reg.st <= sas_pkg::ST_BOOT;
            r_reg.ee_op <= sas_pkg::EE_WRITE_DIRECT;
            r_reg.tear_en <= `SAS_RST_TEAR;
            r_reg.sum_en <= `SAS_RST_SUM;
            r_reg.enc_zones <= NUM_ZONES'(`SAS_RST_ENC_ZONES);
        end else begin
            r_reg <= r_next;
        end
    end

    always_comb begin
        // Encryption implies authentication
        if (r_reg.enc_ok) begin
            o_mode = sas_pkg::MODE_ENC;
        end else if (r_reg.auth_ok) begin
            o_mode = sas_pkg::MODE_AUTH;
        end else begin
            o_mode = sas_pkg::MODE_STD;
        end
    end

    assign o_wb_dat = r_reg.rdata;
    assign o_wb_ack = r_reg.ack;

    assign o_cmd_ready = r_reg.st == sas_pkg::ST_READY;
    assign o_cmd_done = r_reg.done;
    assign o_cmd_refuse = r_reg.refuse;

    assign o_pw_cipher = r_reg.auth_ok;
    assign o_data_cipher = r_reg.enc_ok;
    assign o_mac_mode = r_reg.auth_ok;
    assign o_pw_read_ok = r_reg.pw_active;
    assign o_pw_write_ok = r_reg.pw_active && r_reg.pw_write;
    assign o_pw_set = r_reg.pw_set;
    assign o_cfg_open = r_reg.cfg_open;

    assign o_ee_req = r_reg.ee_req;
    assign o_ee_op = r_reg.ee_op;
    assign o_ee_addr = r_reg.dest;

endmodule

/* common/sas_params.svh */
// Purpose: Constants for the secure access state control block.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes: Offsets, bit positions, reset values, limits and the transport password only.
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

`define SAS_OFS_CTRL 6'h00
`define SAS_OFS_ENC_ZONES 6'h01
`define SAS_OFS_STATUS 6'h02
`define SAS_OFS_CNT_SEL 6'h03
`define SAS_OFS_CNT_DATA 6'h04
`define SAS_OFS_AUTH_CNT 6'h05

`define SAS_CTRL_TEAR_BIT 0
`define SAS_CTRL_SUM_BIT 1

`define SAS_RST_TEAR 1'h0
`define SAS_RST_SUM 1'h0
`define SAS_RST_ENC_ZONES 32'h0000_0000

`define SAS_ST_MODE_LSB 0
`define SAS_ST_PW_ACT_BIT 2
`define SAS_ST_PW_WR_BIT 3
`define SAS_ST_CFG_BIT 4
`define SAS_ST_BUSY_BIT 5
`define SAS_ST_PW_SET_LSB 8

`define SAS_TRANSPORT_PW 24'h70ba2e
`define SAS_TEAR_MAX_BYTES 4'h8

`endif

/* common/sas_pkg.sv */
// Purpose: Shared types of the secure access state control block.
// Assumes: Used with sas_params.svh for numeric constants.
// Notes: Types only.
package sas_pkg;

    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_VERIFY_PW,
        CMD_AUTH,
        CMD_ENC_ACT,
        CMD_RELEASE,
        CMD_IDLE,
        CMD_OTHER
    } sas_cmd_t;

    typedef enum logic [3:0] {
        ST_BOOT,
        ST_RESTORE,
        ST_RESTORE_CLR,
        ST_READY,
        ST_DIRECT,
        ST_BUF,
        ST_MARK,
        ST_COPY,
        ST_UNMARK
    } sas_state_t;

    typedef enum logic [2:0] {
        EE_WRITE_DIRECT,
        EE_WRITE_BUF,
        EE_SET_MARK,
        EE_COPY,
        EE_CLR_MARK
    } sas_ee_op_t;

    typedef enum logic [1:0] {
        MODE_STD,
        MODE_AUTH,
        MODE_ENC
    } sas_mode_t;

endpackage

/* test/sas_ee_model.sv */
// Purpose: EEPROM controller stand-in for the security state block.
// Assumes: One operation at a time, request held until done.
// Notes: The tear mark survives reset like the real cell.
`timescale 1ns/1ps
module sas_ee_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_req,
    input wire sas_pkg::sas_ee_op_t i_op,
    output logic o_done,
    output logic o_mark
);
    int cnt = 0;
    initial o_done = 1'b0;
    initial o_mark = 1'b0;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_done <= 1'b0;
            cnt <= 0;
        end else begin
            o_done <= 1'b0;
            if (i_req && !o_done) begin
                if (cnt != 0) begin
                    cnt <= cnt - 1;
                end else begin
                    o_done <= 1'b1;
                    cnt <= i_slow ? $urandom_range(6, 1) : 0;
                    if (i_op == sas_pkg::EE_SET_MARK) o_mark <= 1'b1;
                    if (i_op == sas_pkg::EE_CLR_MARK) o_mark <= 1'b0;
                end
            end
        end
    end
endmodule

/* test/sas_ctrl_sva.sv */
// Purpose: Session and write sequence checks at the block ports.
// Assumes: One clock domain, reset active high.
// Notes: Bound to every sas_ctrl instance.
`timescale 1ns/1ps
module sas_ctrl_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire sas_pkg::sas_cmd_t i_cmd_code,
    input wire logic i_cmd_ok,
    input wire logic i_cmd_cfg,
    input wire logic [3:0] i_cmd_len,
    input wire logic i_cmd_has_sum,
    input wire logic i_cmd_sum_ok,
    input wire logic o_cmd_ready,
    input wire logic o_cmd_refuse,
    input wire sas_pkg::sas_mode_t o_mode,
    input wire logic o_pw_cipher,
    input wire logic o_data_cipher,
    input wire logic o_mac_mode,
    input wire logic o_pw_read_ok,
    input wire logic o_pw_write_ok,
    input wire logic o_cfg_open,
    input wire logic i_ee_done,
    input wire logic o_ee_req,
    input wire sas_pkg::sas_ee_op_t o_ee_op
);
    logic tk;
    assign tk = i_cmd_valid && o_cmd_ready;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_release_clears: assert property (tk && (i_cmd_code ==
        sas_pkg::CMD_RELEASE || i_cmd_code == sas_pkg::CMD_IDLE) |=>
        !o_pw_read_ok && !o_cfg_open && o_mode == sas_pkg::MODE_STD)
        else $error("session kept after release");
    chk_mac_abort: assert property (tk && o_mac_mode &&
        i_cmd_has_sum && !i_cmd_sum_ok |=> o_cmd_refuse && !o_mac_mode
        && !o_data_cipher) else $error("bad MAC not aborted");
    chk_auth_fail: assert property (tk && i_cmd_code ==
        sas_pkg::CMD_AUTH && !i_cmd_ok |=> o_mode == sas_pkg::MODE_STD
        && !o_mac_mode) else $error("failed auth kept");
    chk_auth_holds: assert property (o_mac_mode && !tk |=>
        o_mac_mode) else $error("auth lost without cause");
    chk_enc_fail: assert property (tk && i_cmd_code ==
        sas_pkg::CMD_ENC_ACT && !i_cmd_ok |=> !o_data_cipher)
        else $error("cipher kept after failed activation");
    chk_write_pw_read: assert property (o_pw_write_ok |->
        o_pw_read_ok) else $error("write password without read");
    chk_pw_cipher: assert property (o_pw_cipher == o_mac_mode &&
        o_mac_mode == (o_mode != sas_pkg::MODE_STD))
        else $error("password cipher not tied to mode");
    chk_enc_order: assert property (o_data_cipher |-> o_mac_mode &&
        o_mode == sas_pkg::MODE_ENC) else $error("cipher without auth");
    chk_cfg_locked: assert property (tk && i_cmd_cfg && !o_cfg_open &&
        (i_cmd_code == sas_pkg::CMD_READ || i_cmd_code ==
        sas_pkg::CMD_WRITE) |=> o_cmd_refuse)
        else $error("config reached while locked");
    chk_long_write: assert property (tk && i_cmd_code ==
        sas_pkg::CMD_WRITE && i_cmd_len > 4'h8 |=> !o_ee_req ||
        o_ee_op == sas_pkg::EE_WRITE_DIRECT)
        else $error("long write sent via buffer");
    chk_buf_mark: assert property (o_ee_req && i_ee_done &&
        o_ee_op == sas_pkg::EE_WRITE_BUF |=> o_ee_req &&
        o_ee_op == sas_pkg::EE_SET_MARK) else $error("buffer not marked");
    chk_copy_clear: assert property (o_ee_req && i_ee_done &&
        o_ee_op == sas_pkg::EE_COPY |=> o_ee_req &&
        o_ee_op == sas_pkg::EE_CLR_MARK) else $error("copy not unmarked");
endmodule
bind sas_ctrl sas_ctrl_sva u_sva (.i_clk, .i_rst, .i_cmd_valid, .i_cmd_code,
    .i_cmd_ok, .i_cmd_cfg, .i_cmd_len, .i_cmd_has_sum, .i_cmd_sum_ok,
    .o_cmd_ready, .o_cmd_refuse, .o_mode, .o_pw_cipher, .o_data_cipher,
    .o_mac_mode, .o_pw_read_ok, .o_pw_write_ok, .o_cfg_open, .i_ee_done,
    .o_ee_req, .o_ee_op);

/* test/testbench.sv */
// Purpose: Self-checking bench for the security state block.
// Assumes: EEPROM controller model on the far side.
// Notes: Expected pulses and read data wait in queues.
`timescale 1ns/1ps
`include "sas_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic i_clk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0, i_cmd_valid = 1'b0, i_cmd_ok = 1'b0;
    logic i_cmd_cfg = 1'b0, i_cmd_pw_write = 1'b0, i_cmd_has_sum = 1'b0;
    logic i_cmd_sum_ok = 1'b0, slow = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'hf, i_cmd_zone = 4'h2, i_cmd_len = 4'h1;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, ed;
    logic [12:0] i_cmd_addr = 13'h0;
    logic [2:0] i_cmd_pw_set = 3'h0;
    logic [23:0] i_cmd_pw = 24'h0;
    sas_pkg::sas_cmd_t i_cmd_code = sas_pkg::CMD_OTHER;
    sas_pkg::sas_mode_t o_mode;
    sas_pkg::sas_ee_op_t o_ee_op;
    logic o_wb_ack, o_cmd_ready, o_cmd_done, o_cmd_refuse, o_data_cipher;
    logic o_mac_mode, o_pw_read_ok, o_pw_write_ok, o_cfg_open;
    logic i_ee_tear_mark, i_ee_done, o_ee_req;
    logic [2:0] o_pw_set;
    logic [12:0] o_ee_addr;
    logic [6:0] q[$], ev, got;
    logic [31:0] rq[$];
    int errors = 0, checked = 0, n, p;
    always #25 i_clk = ~i_clk;
    sas_ctrl DUT (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_cmd_valid, .i_cmd_code,
        .i_cmd_ok, .i_cmd_cfg, .i_cmd_zone, .i_cmd_addr, .i_cmd_len,
        .i_cmd_pw_set, .i_cmd_pw_write, .i_cmd_pw, .i_cmd_has_sum,
        .i_cmd_sum_ok, .o_cmd_ready, .o_cmd_done, .o_cmd_refuse, .o_mode,
        .o_pw_cipher(), .o_data_cipher, .o_mac_mode, .o_pw_read_ok,
        .o_pw_write_ok, .o_pw_set, .o_cfg_open, .i_ee_tear_mark,
        .i_ee_done, .o_ee_req, .o_ee_op, .o_ee_addr);
    sas_ee_model u_ee (.i_clk, .i_rst, .i_slow(slow), .i_req(o_ee_req),
        .i_op(o_ee_op), .o_done(i_ee_done), .o_mark(i_ee_tear_mark));
    assign got = {o_cmd_refuse, o_mode, o_pw_read_ok, o_pw_write_ok,
        o_cfg_open, o_data_cipher};
    always @(posedge i_clk) begin
        if (o_cmd_done === 1'b1 || o_cmd_refuse === 1'b1) begin
            ev = q.size() != 0 ? q.pop_front() : 7'h7f;
            `CHK(got, ev)
        end
        if (o_wb_ack === 1'b1 && i_wb_we === 1'b0 && rq.size() != 0) begin
            ed = rq.pop_front();
            `CHK(o_wb_dat, ed)
        end
    end
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic fail_wait(input int k);
        if (k >= 400) begin
            errors++;
            $display("MISMATCH %0t wait ran out", $time);
            end_of_test();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge i_clk);
        if (!w) rq.push_back(d);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 400);
        fail_wait(n);
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    task automatic go(input sas_pkg::sas_cmd_t c, input logic k, f, h, s);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_cmd_ready !== 1'b1 && n < 400);
        fail_wait(n);
        i_cmd_valid <= 1'b1;
        i_cmd_code <= c;
        i_cmd_ok <= k;
        i_cmd_cfg <= f;
        i_cmd_has_sum <= h;
        i_cmd_sum_ok <= s;
        i_cmd_addr <= 13'($urandom);
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
    endtask
    task automatic cmd(input sas_pkg::sas_cmd_t c, input logic k, f, h, s,
                       input logic [6:0] e);
        q.push_back(e);
        go(c, k, f, h, s);
        n = 0;
        while (q.size() != 0 && n < 400) begin
            @(posedge i_clk);
            n++;
        end
        fail_wait(n);
    endtask
    initial begin
        void'($urandom(21));
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        wb(0, 8'h00, 32'h0);
        wb(0, 8'h04, 32'h0);
        wb(0, 8'h08, 32'h0);
        wb(0, 8'hfc, 32'h0);
        $display("reset values test ended");
        p = $urandom_range(7, 0);
        i_cmd_pw_set <= 3'(p);
        i_cmd_pw_write <= 1'b1;
        i_cmd_pw <= 24'($urandom) & 24'h0f_ffff;
        cmd(sas_pkg::CMD_VERIFY_PW, 1, 0, 0, 0, 7'h0c);
        `CHK(o_pw_set, 3'(p))
        i_cmd_pw_write <= 1'b0;
        cmd(sas_pkg::CMD_VERIFY_PW, 1, 0, 0, 0, 7'h08);
        i_cmd_pw_write <= 1'b1;
        cmd(sas_pkg::CMD_VERIFY_PW, 0, 0, 0, 0, 7'h00);
        wb(1, 8'h0c, 32'(p * 2 + 1));
        wb(0, 8'h10, 32'h1);
        wb(0, 8'h14, 32'h0);
        wb(1, 8'h10, 32'h0);
        wb(0, 8'h10, 32'h0);
        cmd(sas_pkg::CMD_VERIFY_PW, 1, 0, 0, 0, 7'h0c);
        cmd(sas_pkg::CMD_OTHER, 1, 0, 0, 0, 7'h0c);
        cmd(sas_pkg::CMD_IDLE, 1, 0, 0, 0, 7'h00);
        $display("password test ended");
        cmd(sas_pkg::CMD_READ, 1, 1, 0, 0, 7'h40);
        i_cmd_pw <= `SAS_TRANSPORT_PW;
        cmd(sas_pkg::CMD_VERIFY_PW, 0, 0, 0, 0, 7'h02);
        cmd(sas_pkg::CMD_WRITE, 1, 1, 0, 0, 7'h02);
        cmd(sas_pkg::CMD_RELEASE, 1, 0, 0, 0, 7'h00);
        $display("transport password test ended");
        cmd(sas_pkg::CMD_AUTH, 0, 0, 0, 0, 7'h00);
        wb(0, 8'h14, 32'h1);
        cmd(sas_pkg::CMD_ENC_ACT, 1, 0, 0, 0, 7'h00);
        cmd(sas_pkg::CMD_AUTH, 1, 0, 0, 0, 7'h10);
        cmd(sas_pkg::CMD_ENC_ACT, 1, 0, 0, 0, 7'h21);
        cmd(sas_pkg::CMD_ENC_ACT, 0, 0, 0, 0, 7'h10);
        cmd(sas_pkg::CMD_WRITE, 1, 0, 0, 0, 7'h50);
        cmd(sas_pkg::CMD_AUTH, 0, 0, 0, 0, 7'h00);
        $display("session mode test ended");
        i_cmd_zone <= 4'h5;
        wb(1, 8'h04, 32'h0000_0020);
        cmd(sas_pkg::CMD_READ, 1, 0, 0, 0, 7'h40);
        cmd(sas_pkg::CMD_AUTH, 1, 0, 0, 0, 7'h10);
        cmd(sas_pkg::CMD_ENC_ACT, 1, 0, 0, 0, 7'h21);
        cmd(sas_pkg::CMD_READ, 1, 0, 0, 0, 7'h21);
        cmd(sas_pkg::CMD_WRITE, 1, 0, 1, 0, 7'h40);
        $display("encrypted zone test ended");
        i_cmd_zone <= 4'h2;
        wb(1, 8'h00, 32'h2);
        cmd(sas_pkg::CMD_WRITE, 1, 0, 1, 0, 7'h40);
        cmd(sas_pkg::CMD_WRITE, 1, 0, 0, 0, 7'h00);
        wb(1, 8'h00, 32'h0);
        cmd(sas_pkg::CMD_WRITE, 1, 0, 1, 0, 7'h00);
        $display("checksum test ended");
        slow <= 1'b1;
        wb(1, 8'h00, 32'h1);
        wb(0, 8'h00, 32'h1);
        i_cmd_len <= 4'h8;
        cmd(sas_pkg::CMD_WRITE, 1, 0, 0, 0, 7'h00);
        i_cmd_len <= 4'h9;
        cmd(sas_pkg::CMD_WRITE, 1, 0, 0, 0, 7'h40);
        $display("anti-tearing test ended");
        i_cmd_len <= 4'h4;
        go(sas_pkg::CMD_WRITE, 1, 0, 0, 0);
        n = 0;
        while (!(o_ee_req === 1'b1 && o_ee_op === sas_pkg::EE_COPY)
               && n < 400) begin
            @(posedge i_clk);
            n++;
        end
        fail_wait(n);
        `CHK(o_ee_addr, i_cmd_addr)
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_ee_req !== 1'b1 && n < 400);
        fail_wait(n);
        `CHK(o_ee_op, sas_pkg::EE_COPY)
        cmd(sas_pkg::CMD_READ, 1, 0, 0, 0, 7'h00);
        wb(0, 8'h00, 32'h0);
        $display("power-up restore test ended");
        end_of_test();
    end
endmodule
